// ### bench/host_model.sv
// Host side of the register port: single-strobe register writes and reads
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // ======================================
  // Bus cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // Released lines are scrambled so a stale value never looks live
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rdata;
  endtask : rd
endmodule : host_model

// ### bench/tb_balance_adc_status_config.sv
// Self-checking bench for the balancing status and converter setup bank
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb_balance_adc_status_config;
  localparam logic [15:0] ST_BAL = bal_adc_pkg::OFS_BAL_STATE;
  localparam logic [15:0] ST_RUN = bal_adc_pkg::OFS_RUN_FLAGS;
  localparam logic [15:0] CFG_OFS [8] = '{bal_adc_pkg::OFS_SETTLE_FILTER,
    bal_adc_pkg::OFS_START_DELAY, bal_adc_pkg::OFS_PRI_GAIN_LO, bal_adc_pkg::OFS_PRI_GAIN_HI_OFS,
    bal_adc_pkg::OFS_SEC_GAIN_LO, bal_adc_pkg::OFS_SEC_GAIN_HI_OFS, bal_adc_pkg::OFS_CUR_GAIN_LO,
    bal_adc_pkg::OFS_CUR_GAIN_HI_OFS};
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] reg_addr;
  logic reg_wr, reg_rd, otp_valid = 1'b0;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [63:0] otp_image = 64'h0;
  logic [15:0] cell_select = 16'h0000;
  logic balance_start_ctl = 1'b0, forbid_neighbour_balancing = 1'b0;
  logic balance_overtemp_check_enable = 1'b0, thermistor_over_threshold = 1'b0;
  logic die_temp_warning = 1'b0, host_pause_ctl = 1'b0, cells_balancing = 1'b0;
  logic all_cells_done = 1'b0, unmasked_fault = 1'b0, main_conv_start = 1'b0;
  logic cust_check_done = 1'b0, fact_check_done = 1'b0;
  logic temp_protector_start = 1'b0, temp_protector_end = 1'b0;
  logic volt_protector_start = 1'b0, volt_protector_end = 1'b0;
  logic [1:0] temp_protector_select = 2'h0, volt_protector_select = 2'h0;
  logic cur_conv_on = 1'b0, sec_conv_on = 1'b0, pri_conv_on = 1'b0;
  logic balance_enable, balance_abort, temp_comparators_on, volt_comparators_on;
  logic converters_enable;
  logic [18:0] secondary_settle_cycles;
  logic [12:0] cell_filter_cutoff, current_filter_cutoff;
  logic [8:0] pri_gain_trim, sec_gain_trim;
  logic [6:0] pri_offset_trim, sec_offset_trim;
  logic [10:0] cur_gain_trim;
  logic [4:0] cur_offset_trim;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  balance_adc_status_config balance_adc_status_config_inst (.sys_clk, .rstn, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .otp_valid, .otp_image, .balance_start_ctl,
    .cell_select, .forbid_neighbour_balancing, .balance_overtemp_check_enable,
    .thermistor_over_threshold, .die_temp_warning, .host_pause_ctl, .cells_balancing,
    .all_cells_done, .unmasked_fault, .cust_check_done, .fact_check_done,
    .temp_protector_start, .temp_protector_select, .temp_protector_end, .volt_protector_start,
    .volt_protector_select, .volt_protector_end, .main_conv_start, .cur_conv_on, .sec_conv_on,
    .pri_conv_on, .balance_enable, .balance_abort, .temp_comparators_on, .volt_comparators_on,
    .converters_enable, .secondary_settle_cycles, .cell_filter_cutoff, .current_filter_cutoff,
    .pri_gain_trim, .pri_offset_trim, .sec_gain_trim, .sec_offset_trim, .cur_gain_trim,
    .cur_offset_trim);
  host_model host_model_inst (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  // ======================================
  // Clock, timeout and verdict
  always #5 sys_clk = ~sys_clk;
  // Longest scenario is the top delay code, about 20000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      results();
    end
  end
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic do_reset();
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask : do_reset
  task automatic flags(input logic [15:0] a, input logic [7:0] m, input logic [7:0] ex);
    host_model_inst.rd(a, d);
    `CHK("status flags", ex, d & m)
  endtask : flags
  task automatic cfg_check(input logic [63:0] img);
    for (int i = 0; i < 8; i++) begin
      host_model_inst.rd(CFG_OFS[i], d);
      `CHK("config readback", img[8*i +: 8], d)
    end
    `CHK("primary gain", {img[31], img[23:16]}, pri_gain_trim)
    `CHK("primary offset", img[30:24], pri_offset_trim)
    `CHK("secondary gain", {img[47], img[39:32]}, sec_gain_trim)
    `CHK("secondary offset", img[46:40], sec_offset_trim)
    `CHK("current gain", {img[63:61], img[55:48]}, cur_gain_trim)
    `CHK("current offset", img[60:56], cur_offset_trim)
  endtask : cfg_check
  // ======================================
  // Scenarios
  task automatic test_registers();
    cfg_check(64'h0);
    host_model_inst.wr(ST_BAL, 8'hff);
    host_model_inst.wr(16'h0100, 8'h5a);
    flags(ST_BAL, 8'hff, 8'h00);
    flags(16'h0100, 8'hff, 8'h00);
    @(posedge sys_clk);
    otp_image <= 64'he76bc43d9a812955;
    otp_valid <= 1'b1;
    @(posedge sys_clk);
    otp_valid <= 1'b0;
    cfg_check(64'he76bc43d9a812955);
    for (int i = 0; i < 8; i++) begin
      host_model_inst.wr(CFG_OFS[i], 8'(8'h1e * i + 8'h93));
    end
    cfg_check(64'h6547290bedcfb193);
  endtask : test_registers
  task automatic test_decode();
    logic [2:0] c;
    logic [18:0] es;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      host_model_inst.wr(bal_adc_pkg::OFS_SETTLE_FILTER, {c[1:0], c, ~c});
      tick(2);
      es = (c[1:0] == 2'd1) ? 19'(bal_adc_pkg::SETTLE1_CYC) :
           (c[1:0] == 2'd2) ? 19'(bal_adc_pkg::SETTLE2_CYC) : 19'(bal_adc_pkg::SETTLE0_CYC);
      `CHK("settle cycles", es, secondary_settle_cycles)
      `CHK("current cutoff", bal_adc_pkg::CUTOFF_DHZ[c], current_filter_cutoff)
      `CHK("cell cutoff", bal_adc_pkg::CUTOFF_DHZ[~c], cell_filter_cutoff)
    end
  endtask : test_decode
  task automatic bal_start(input logic [15:0] sel, input logic nadj);
    @(posedge sys_clk);
    cell_select <= sel;
    forbid_neighbour_balancing <= nadj;
    balance_start_ctl <= 1'b1;
    @(posedge sys_clk);
    balance_start_ctl <= 1'b0;
  endtask : bal_start
  task automatic test_balancing();
    @(posedge sys_clk);
    cells_balancing <= 1'b1;
    bal_start(16'hd555, 1'b0);
    flags(ST_BAL, 8'h80, 8'h80);
    `CHK("enable after refusal", 1'b0, balance_enable)
    bal_start(16'h0007, 1'b0);
    flags(ST_BAL, 8'h80, 8'h80);
    bal_start(16'h0003, 1'b1);
    flags(ST_BAL, 8'h80, 8'h80);
    bal_start(16'h0003, 1'b0);
    flags(ST_BAL, 8'hff, 8'h08);
    `CHK("enable when started", 1'b1, balance_enable)
    @(posedge sys_clk);
    host_pause_ctl <= 1'b1;
    tick(2);
    @(posedge sys_clk);
    unmasked_fault <= 1'b1;
    flags(ST_BAL, 8'hff, 8'h28);
    `CHK("enable in pause", 1'b0, balance_enable)
    @(posedge sys_clk);
    host_pause_ctl <= 1'b0;
    tick(1);
    `CHK("abort pulse", 1'b1, balance_abort)
    tick(2);
    flags(ST_BAL, 8'h24, 8'h04);
    @(posedge sys_clk);
    unmasked_fault <= 1'b0;
    bal_start(16'h0003, 1'b0);
    flags(ST_BAL, 8'h04, 8'h00);
    @(posedge sys_clk);
    all_cells_done <= 1'b1;
    cells_balancing <= 1'b0;
    tick(2);
    flags(ST_BAL, 8'h09, 8'h01);
    @(posedge sys_clk);
    all_cells_done <= 1'b0;
    bal_start(16'h0003, 1'b0);
    flags(ST_BAL, 8'h01, 8'h00);
    @(posedge sys_clk);
    die_temp_warning <= 1'b1;
    tick(2);
    flags(ST_BAL, 8'h60, 8'h60);
    do_reset();
    die_temp_warning <= 1'b0;
    cells_balancing <= 1'b1;
    thermistor_over_threshold <= 1'b1;
    bal_start(16'h0005, 1'b1);
    flags(ST_BAL, 8'h40, 8'h00);
    @(posedge sys_clk);
    balance_overtemp_check_enable <= 1'b1;
    tick(2);
    flags(ST_BAL, 8'h60, 8'h60);
  endtask : test_balancing
  task automatic test_run_flags();
    @(posedge sys_clk);
    cust_check_done <= 1'b1;
    fact_check_done <= 1'b1;
    @(posedge sys_clk);
    cust_check_done <= 1'b0;
    fact_check_done <= 1'b0;
    host_model_inst.wr(ST_RUN, 8'h00);
    flags(ST_RUN, 8'h60, 8'h60);
    flags(ST_RUN, 8'h60, 8'h00);
    @(posedge sys_clk);
    {temp_protector_start, volt_protector_start, cur_conv_on, pri_conv_on} <= 4'hf;
    {temp_protector_select, volt_protector_select} <= 4'h6;
    @(posedge sys_clk);
    {temp_protector_start, volt_protector_start} <= 2'b00;
    flags(ST_RUN, 8'h1f, 8'h1d);
    `CHK("comparators on", 2'b11, {temp_comparators_on, volt_comparators_on})
    @(posedge sys_clk);
    {temp_protector_end, volt_protector_end} <= 2'b11;
    @(posedge sys_clk);
    {temp_protector_end, volt_protector_end} <= 2'b00;
    #1;
    `CHK("comparators off", 2'b00, {temp_comparators_on, volt_comparators_on})
    flags(ST_RUN, 8'h18, 8'h00);
    @(posedge sys_clk);
    {temp_protector_start, volt_protector_start} <= 2'b11;
    {temp_protector_select, volt_protector_select} <= 4'h0;
    @(posedge sys_clk);
    {temp_protector_start, volt_protector_start} <= 2'b00;
    flags(ST_RUN, 8'h18, 8'h00);
  endtask : test_run_flags
  task automatic conv_delay(input logic [5:0] code);
    int n;
    int ex;
    ex = (code <= bal_adc_pkg::DLY_MAX_CODE) ? int'(code) * bal_adc_pkg::DLY_STEP_CYC + 3 : 3;
    host_model_inst.wr(bal_adc_pkg::OFS_START_DELAY, {2'b00, code});
    @(posedge sys_clk);
    main_conv_start <= 1'b1;
    @(posedge sys_clk);
    main_conv_start <= 1'b0;
    // Count from the edge that raises the start strobe
    n = 1;
    do begin
      tick(1);
      n++;
    end while (converters_enable !== 1'b1 && n < 25000);
    `CHK("start delay cycles", ex, n)
    tick(1);
    `CHK("enable pulse width", 1'b0, converters_enable)
  endtask : conv_delay
  initial begin
    do_reset();
    test_registers();
    test_decode();
    test_balancing();
    test_run_flags();
    conv_delay(6'd0);
    conv_delay(6'd1);
    conv_delay(6'd40);
    conv_delay(6'd41);
    results();
  end
endmodule : tb_balance_adc_status_config

// ### rtl/bal_adc_pkg.sv
// Package: offsets, field positions, reset values and timing counts for the status/config bank
package bal_adc_pkg;
  // Register offsets
  localparam logic [15:0] OFS_SETTLE_FILTER = 16'h0007;
  localparam logic [15:0] OFS_START_DELAY = 16'h0008;
  localparam logic [15:0] OFS_PRI_GAIN_LO = 16'h001b;
  localparam logic [15:0] OFS_PRI_GAIN_HI_OFS = 16'h001c;
  localparam logic [15:0] OFS_SEC_GAIN_LO = 16'h001d;
  localparam logic [15:0] OFS_SEC_GAIN_HI_OFS = 16'h001e;
  localparam logic [15:0] OFS_CUR_GAIN_LO = 16'h001f;
  localparam logic [15:0] OFS_CUR_GAIN_HI_OFS = 16'h0020;
  localparam logic [15:0] OFS_BAL_STATE = 16'h052b;
  localparam logic [15:0] OFS_RUN_FLAGS = 16'h052c;
  // Reset values
  localparam logic [7:0] RST_CONF = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  // Balancing state flag positions
  localparam int BIT_BAD_CFG = 7;
  localparam int BIT_OT_PAUSE = 6;
  localparam int BIT_PAUSED = 5;
  localparam int BIT_ACTIVE = 3;
  localparam int BIT_ABORT = 2;
  localparam int BIT_FINISHED = 0;
  // Run flag positions
  localparam int BIT_FACT_DONE = 6;
  localparam int BIT_CUST_DONE = 5;
  localparam int BIT_TEMP_RUN = 4;
  localparam int BIT_VOLT_RUN = 3;
  localparam int BIT_CUR_RUN = 2;
  localparam int BIT_SEC_RUN = 1;
  localparam int BIT_PRI_RUN = 0;
  // Balancing selection limits
  localparam int MAX_BAL_CELLS = 8;
  localparam int MAX_ADJ_CELLS = 2;
  localparam int NUM_CELLS = 16;
  // Settling and delay timing, clock 100 MHz
  localparam int CLK_HZ = 100_000_000;
  localparam int SETTLE0_US = 4300;
  localparam int SETTLE1_US = 2300;
  localparam int SETTLE2_US = 1300;
  localparam int SETTLE0_CYC = SETTLE0_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE1_CYC = SETTLE1_US * (CLK_HZ / 1_000_000);
  localparam int SETTLE2_CYC = SETTLE2_US * (CLK_HZ / 1_000_000);
  localparam int DLY_STEP_US = 5;
  localparam int DLY_STEP_CYC = DLY_STEP_US * (CLK_HZ / 1_000_000);
  localparam int DLY_MAX_US = 200;
  localparam logic [5:0] DLY_MAX_CODE = 6'(DLY_MAX_US / DLY_STEP_US);
  // Filter cut-off table in tenths of a hertz
  localparam logic [12:0] CUTOFF_DHZ [8] = '{13'd65, 13'd130, 13'd260, 13'd530,
                                             13'd1110, 13'd2400, 13'd6000, 13'd2400};
  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_WAIT = 2'b01,
    DLY_GO = 2'b11
  } dly_state_t;
endpackage : bal_adc_pkg

// ### rtl/balance_adc_status_config.sv
// Balancing/run status flags and converter configuration register bank
// What this block does
// - Balancing start refused and bad-setting flag set if over eight cells selected.
// - Neighbour rule: option 0 allows two adjacent, option 1 allows none.
// - Bad-setting flag recomputed on every balancing start write of one.
// - Over-temperature pause flag set by thermistor check or die warning, after start.
// - Paused flag is one while paused by temperature or host pause control.
// - Active flag holds one while any cell balances, paused included.
// - Fault abort flag set on unmasked fault stop, cleared by start write.
// - No fault abort while paused; abort resumes when pause ends.
// - Finished flag set when all selected cells done, cleared by start write.
// - Customer and factory check finished flags set when checks complete.
// - Host read of run flags register clears both check finished flags.
// - Temperature protector active set at start, cleared on the same edge as comparators off.
// - Voltage protector active set at start, cleared on the same edge as comparators off.
// - Protector active shows on for nonzero select, off for zero select.
// - Secondary settle code 00/01/10 gives 4.3/2.3/1.3 ms; 11 reserved.
// - Cell and current filter cut-off from one 3-bit code table.
// - Converter enable delayed 0 to 200 us in 5 us steps; undefined is zero.
// - Gain trim words reset to zero, loaded from OTP when otp_valid is high, and driven out on the gain trim outputs.
// - Offset trim words reset to zero, loaded from OTP when otp_valid is high, and driven out on the offset trim outputs.
// - Primary/secondary gain is 9 bits: eight low plus one high.
// - Primary/secondary offset is a 7-bit value.
// - Current gain trim is eight low plus three high bits.
// - Current offset trim is a 5-bit value.
// - Writing one to main start begins conversion; writing zero does nothing.
`timescale 1ns/1ps
module balance_adc_status_config (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic otp_valid,
  input wire logic [63:0] otp_image,
  input wire logic balance_start_ctl,
  input wire logic [15:0] cell_select,
  input wire logic forbid_neighbour_balancing,
  input wire logic balance_overtemp_check_enable,
  input wire logic thermistor_over_threshold,
  input wire logic die_temp_warning,
  input wire logic host_pause_ctl,
  input wire logic cells_balancing,
  input wire logic all_cells_done,
  input wire logic unmasked_fault,
  input wire logic cust_check_done,
  input wire logic fact_check_done,
  input wire logic temp_protector_start,
  input wire logic [1:0] temp_protector_select,
  input wire logic temp_protector_end,
  input wire logic volt_protector_start,
  input wire logic [1:0] volt_protector_select,
  input wire logic volt_protector_end,
  input wire logic main_conv_start,
  input wire logic cur_conv_on,
  input wire logic sec_conv_on,
  input wire logic pri_conv_on,
  output logic balance_enable,
  output logic balance_abort,
  output logic temp_comparators_on,
  output logic volt_comparators_on,
  output logic converters_enable,
  output logic [18:0] secondary_settle_cycles,
  output logic [12:0] cell_filter_cutoff,
  output logic [12:0] current_filter_cutoff,
  output logic [8:0] pri_gain_trim,
  output logic [6:0] pri_offset_trim,
  output logic [8:0] sec_gain_trim,
  output logic [6:0] sec_offset_trim,
  output logic [10:0] cur_gain_trim,
  output logic [4:0] cur_offset_trim
);
  // ==========================================================
  // Configuration registers
  logic [7:0] conf_q [8];
  logic [7:0] bal_q;
  logic [7:0] run_q;
  logic started_q;
  logic [15:0] adj2_w;
  logic [15:0] adj1_w;
  logic [4:0] cnt_w;
  logic too_many_w;
  logic adj_bad_w;
  logic bad_w;
  logic paused_w;
  logic abort_w;
  logic ot_w;
  logic [15:0] offs_w [8];
  logic rd_run_w;
  logic [7:0] rdata_d;
  logic [7:0] bal_d;
  logic [7:0] run_d;
  assign offs_w = '{bal_adc_pkg::OFS_SETTLE_FILTER, bal_adc_pkg::OFS_START_DELAY,
                    bal_adc_pkg::OFS_PRI_GAIN_LO, bal_adc_pkg::OFS_PRI_GAIN_HI_OFS,
                    bal_adc_pkg::OFS_SEC_GAIN_LO, bal_adc_pkg::OFS_SEC_GAIN_HI_OFS,
                    bal_adc_pkg::OFS_CUR_GAIN_LO, bal_adc_pkg::OFS_CUR_GAIN_HI_OFS};

  // Reset value first, OTP image lands once it is valid after release
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_conf
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          conf_q[gi] <= bal_adc_pkg::RST_CONF;
        end else if (otp_valid) begin
          conf_q[gi] <= otp_image[gi*8 +: 8];
        end else if (reg_wr && reg_addr == offs_w[gi]) begin
          conf_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Balancing setting check
  assign adj1_w = cell_select & {1'b0, cell_select[15:1]};
  assign adj2_w = adj1_w & {1'b0, adj1_w[15:1]};
  always_comb begin
    cnt_w = 5'd0;
    for (int i = 0; i < bal_adc_pkg::NUM_CELLS; i++) begin
      cnt_w = cnt_w + 5'(cell_select[i]);
    end
  end
  assign too_many_w = cnt_w > 5'(bal_adc_pkg::MAX_BAL_CELLS);
  // Three in a row means more than two adjacent
  assign adj_bad_w = forbid_neighbour_balancing ? (|adj1_w) : (|adj2_w);
  assign bad_w = too_many_w | adj_bad_w;
  assign ot_w = (balance_overtemp_check_enable & thermistor_over_threshold) |
                die_temp_warning;
  assign paused_w = started_q & (bal_q[bal_adc_pkg::BIT_OT_PAUSE] | host_pause_ctl);
  // Abort is masked while paused so a hot pause cannot kill the run
  assign abort_w = started_q & cells_balancing & unmasked_fault & ~paused_w;
  assign rd_run_w = reg_rd && reg_addr == bal_adc_pkg::OFS_RUN_FLAGS;

  always_comb begin
    bal_d = bal_q;
    if (balance_start_ctl) begin
      bal_d[bal_adc_pkg::BIT_BAD_CFG] = bad_w;
      bal_d[bal_adc_pkg::BIT_ABORT] = 1'b0;
      bal_d[bal_adc_pkg::BIT_FINISHED] = 1'b0;
    end
    bal_d[bal_adc_pkg::BIT_OT_PAUSE] = started_q & ot_w;
    bal_d[bal_adc_pkg::BIT_PAUSED] = paused_w;
    bal_d[bal_adc_pkg::BIT_ACTIVE] = started_q & cells_balancing;
    if (abort_w) begin
      bal_d[bal_adc_pkg::BIT_ABORT] = 1'b1;
    end
    if (started_q && all_cells_done) begin
      bal_d[bal_adc_pkg::BIT_FINISHED] = 1'b1;
    end
  end

  always_comb begin
    run_d = run_q;
    if (rd_run_w) begin
      run_d[bal_adc_pkg::BIT_FACT_DONE] = 1'b0;
      run_d[bal_adc_pkg::BIT_CUST_DONE] = 1'b0;
    end
    // Set wins over the clear-on-read
    if (cust_check_done) begin
      run_d[bal_adc_pkg::BIT_CUST_DONE] = 1'b1;
    end
    if (fact_check_done) begin
      run_d[bal_adc_pkg::BIT_FACT_DONE] = 1'b1;
    end
    if (temp_protector_end) begin
      run_d[bal_adc_pkg::BIT_TEMP_RUN] = 1'b0;
    end
    if (temp_protector_start) begin
      run_d[bal_adc_pkg::BIT_TEMP_RUN] = |temp_protector_select;
    end
    if (volt_protector_end) begin
      run_d[bal_adc_pkg::BIT_VOLT_RUN] = 1'b0;
    end
    if (volt_protector_start) begin
      run_d[bal_adc_pkg::BIT_VOLT_RUN] = |volt_protector_select;
    end
    run_d[bal_adc_pkg::BIT_CUR_RUN] = cur_conv_on;
    run_d[bal_adc_pkg::BIT_SEC_RUN] = sec_conv_on;
    run_d[bal_adc_pkg::BIT_PRI_RUN] = pri_conv_on;
  end

  // Status registers have no write path at all
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bal_q <= bal_adc_pkg::RST_STATUS;
      run_q <= bal_adc_pkg::RST_STATUS;
      started_q <= 1'b0;
    end else begin
      bal_q <= bal_d;
      run_q <= run_d;
      if (balance_start_ctl) begin
        started_q <= ~bad_w;
      end else if (abort_w || all_cells_done) begin
        started_q <= 1'b0;
      end
    end
  end

  // Comparators and the active flag drop on one edge, so the flag never reads off first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      temp_comparators_on <= 1'b0;
      volt_comparators_on <= 1'b0;
    end else begin
      temp_comparators_on <= run_d[bal_adc_pkg::BIT_TEMP_RUN] & ~temp_protector_end;
      volt_comparators_on <= run_d[bal_adc_pkg::BIT_VOLT_RUN] & ~volt_protector_end;
    end
  end

  // ==========================================================
  // Conversion start delay
  bal_adc_pkg::dly_state_t st_q;
  logic [5:0] steps_q;
  logic [8:0] sub_q;
  logic [5:0] code_w;
  assign code_w = conf_q[1][5:0];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= bal_adc_pkg::DLY_IDLE;
      steps_q <= 6'h00;
      sub_q <= 9'h000;
    end else begin
      case (st_q)
        bal_adc_pkg::DLY_IDLE: begin
          if (main_conv_start) begin
            st_q <= bal_adc_pkg::DLY_WAIT;
            steps_q <= (code_w > bal_adc_pkg::DLY_MAX_CODE) ? 6'h00 : code_w;
            sub_q <= 9'h000;
          end
        end
        // A start seen while counting is dropped; the host waits for the enable pulse
        bal_adc_pkg::DLY_WAIT: begin
          if (steps_q == 6'h00) begin
            st_q <= bal_adc_pkg::DLY_GO;
          end else if (sub_q == 9'(bal_adc_pkg::DLY_STEP_CYC - 1)) begin
            sub_q <= 9'h000;
            steps_q <= steps_q - 6'h01;
          end else begin
            sub_q <= sub_q + 9'h001;
          end
        end
        bal_adc_pkg::DLY_GO: begin
          st_q <= bal_adc_pkg::DLY_IDLE;
        end
        default: begin
          st_q <= bal_adc_pkg::DLY_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Read mux and registered outputs
  always_comb begin
    rdata_d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (reg_addr == offs_w[i]) begin
        rdata_d = conf_q[i];
      end
    end
    if (reg_addr == bal_adc_pkg::OFS_BAL_STATE) begin
      rdata_d = bal_q;
    end
    if (reg_addr == bal_adc_pkg::OFS_RUN_FLAGS) begin
      rdata_d = run_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      balance_enable <= 1'b0;
      balance_abort <= 1'b0;
      converters_enable <= 1'b0;
      secondary_settle_cycles <= 19'h00000;
      cell_filter_cutoff <= 13'h0000;
      current_filter_cutoff <= 13'h0000;
      pri_gain_trim <= 9'h000;
      pri_offset_trim <= 7'h00;
      sec_gain_trim <= 9'h000;
      sec_offset_trim <= 7'h00;
      cur_gain_trim <= 11'h000;
      cur_offset_trim <= 5'h00;
    end else begin
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
      balance_enable <= started_q & ~paused_w & ~abort_w;
      balance_abort <= abort_w;
      converters_enable <= st_q == bal_adc_pkg::DLY_GO;
      // Reserved code falls back to the longest settle, the safe choice
      case (conf_q[0][7:6])
        2'b00: secondary_settle_cycles <= 19'(bal_adc_pkg::SETTLE0_CYC);
        2'b01: secondary_settle_cycles <= 19'(bal_adc_pkg::SETTLE1_CYC);
        2'b10: secondary_settle_cycles <= 19'(bal_adc_pkg::SETTLE2_CYC);
        default: secondary_settle_cycles <= 19'(bal_adc_pkg::SETTLE0_CYC);
      endcase
      cell_filter_cutoff <= bal_adc_pkg::CUTOFF_DHZ[conf_q[0][2:0]];
      current_filter_cutoff <= bal_adc_pkg::CUTOFF_DHZ[conf_q[0][5:3]];
      pri_gain_trim <= {conf_q[3][7], conf_q[2]};
      pri_offset_trim <= conf_q[3][6:0];
      sec_gain_trim <= {conf_q[5][7], conf_q[4]};
      sec_offset_trim <= conf_q[5][6:0];
      cur_gain_trim <= {conf_q[7][7:5], conf_q[6]};
      cur_offset_trim <= conf_q[7][4:0];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  bad_count_a: assert property (balance_start_ctl && too_many_w |=>
    bal_q[bal_adc_pkg::BIT_BAD_CFG] && !started_q) else $error("bad count not flagged");
  neighbour_a: assert property (balance_start_ctl && forbid_neighbour_balancing && |adj1_w |=>
    bal_q[bal_adc_pkg::BIT_BAD_CFG]) else $error("neighbour not flagged");
  start_clear_a: assert property (balance_start_ctl && !abort_w && !all_cells_done |=>
    !bal_q[bal_adc_pkg::BIT_ABORT] && !bal_q[bal_adc_pkg::BIT_FINISHED])
    else $error("start did not clear");
  pause_abort_a: assert property (paused_w |=> !balance_abort)
    else $error("abort during pause");
  crc_read_a: assert property (rd_run_w && !cust_check_done |=>
    !run_q[bal_adc_pkg::BIT_CUST_DONE]) else $error("read did not clear");
  temp_order_a: assert property (temp_protector_end && !temp_protector_start |=>
    !temp_comparators_on ##0 !run_q[bal_adc_pkg::BIT_TEMP_RUN])
    else $error("temp protector end");
  volt_sel_a: assert property (volt_protector_start && !volt_protector_end |=>
    run_q[bal_adc_pkg::BIT_VOLT_RUN] == $past(|volt_protector_select))
    else $error("volt select");
  delay_zero_a: assert property (st_q == bal_adc_pkg::DLY_IDLE && main_conv_start &&
    code_w == 6'h00 |=> ##2 converters_enable) else $error("zero delay wrong");
  active_a: assert property (started_q && cells_balancing |=>
    bal_q[bal_adc_pkg::BIT_ACTIVE]) else $error("active flag");
  start_cv: cover property (balance_start_ctl && !bad_w);
  abort_cv: cover property (balance_abort);
  delay_cv: cover property (main_conv_start && code_w == 6'h01);
endmodule : balance_adc_status_config
